// [include/power_state_pkg.sv]
package power_state_pkg;

	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned PULSE_TIME_MS = 50;
	localparam int unsigned RESUME_TIME_US = 2000;
	localparam int unsigned PULSE_CYCLES_DEF = (PULSE_TIME_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned RESUME_CYCLES_DEF = (RESUME_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned TIMER_W = 20;

	// Register byte addresses
	localparam logic [7:0] ADDR_PMT = 8'h00;
	localparam logic [7:0] ADDR_INTERRUPT_STATUS_REG = 8'h04;
	localparam logic [7:0] ADDR_BYTE_TEST = 8'h08;
	localparam logic [7:0] ADDR_PHY_CTRL = 8'h0c;
	localparam logic [23:0] ADDR_HIGH_ZERO = 24'h000000;

	// Power management control fields
	localparam int unsigned PMT_READY_BIT = 0;
	localparam int unsigned PMT_PME_EN_BIT = 1;
	localparam int unsigned PMT_PULSE_BIT = 3;
	localparam int unsigned PMT_WS_LO = 4;
	localparam int unsigned PMT_WS_HI = 5;
	localparam int unsigned PMT_WFE_BIT = 9;
	localparam int unsigned PMT_MODE_LO = 12;
	localparam int unsigned PMT_MODE_HI = 13;
	localparam int unsigned PMT_EDE_BIT = 14;

	// Interrupt status fields
	localparam int unsigned INT_EVENT_BIT = 0;

	// PHY control fields
	localparam int unsigned PHY_ED_INT_EN_BIT = 0;
	localparam int unsigned PHY_ED_FLAG_BIT = 1;
	localparam int unsigned PHY_GPD_BIT = 11;
	localparam int unsigned PHY_EDPD_BIT = 13;

	// Encodings
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_WON = 2'h1;
	localparam logic [1:0] MODE_ENERGY = 2'h2;
	localparam logic [1:0] WS_NONE = 2'h0;
	localparam logic [1:0] WS_ENERGY = 2'h1;
	localparam logic [1:0] WS_FRAME = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	localparam int unsigned HTRANS_ACTIVE_BIT = 1;

	// Arbitrary fixed test pattern
	localparam logic [31:0] BYTE_TEST_PATTERN = 32'h5a5a0ff0;

	typedef enum logic [2:0] {
		normal_state = 3'b001,
		wake_on_network_state = 3'b010,
		energy_detect_state = 3'b100
	} power_state_t;

endpackage

// [src/input_sync3.sv]
`timescale 1ns/1ps
module input_sync3
	import power_state_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);

	logic ff1;
	logic ff2;
	logic ff3;

	// Three stages; output follows once the last two agree
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ff1 <= 1'b0;
			ff2 <= 1'b0;
			ff3 <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			ff1 <= async_in;
			ff2 <= ff1;
			ff3 <= ff2;
			if (ff2 == ff3)
				sync_out <= ff3;
		end
	end

endmodule

// [src/countdown_timer.sv]
`timescale 1ns/1ps
module countdown_timer
	import power_state_pkg::*;
#(
	parameter int unsigned CYCLES = 1,
	parameter int unsigned W = TIMER_W
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic start,
	output logic busy,
	output logic done
);

	logic [W-1:0] count;
	wire last_tick = (count == W'(1)) && !start;

	// Loads on start, counts down to zero
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count <= '0;
			done <= 1'b0;
		end
		else
		begin
			if (start)
				count <= W'(CYCLES);
			else if (count != '0)
				count <= count - 1'b1;
			done <= last_tick;
		end
	end

	assign busy = (count != '0);

endmodule

// [src/ethernet_power_state_manager.sv]
`timescale 1ns/1ps
module ethernet_power_state_manager
	import power_state_pkg::*;
#(
	parameter int unsigned PULSE_CYCLES = PULSE_CYCLES_DEF,
	parameter int unsigned RESUME_CYCLES = RESUME_CYCLES_DEF
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic [1:0] hresp,
	input wire logic wake_frame_detect,
	input wire logic carrier_energy_in,
	output logic pme_pin,
	output logic host_mac_clk_en,
	output logic rx_pm_clk_en,
	output logic internal_clk_en,
	output logic phy_general_powerdown,
	output logic phy_energy_powerdown,
	output logic phy_reset,
	output logic line_energy_present,
	output logic phy_irq
);

	// Bus capture
	logic pend;
	logic wr_q;
	logic valid_q;
	logic [7:0] addr_q;

	// Power state and control
	power_state_t state;
	logic ready;
	logic read_seen;
	logic pme_en;
	logic pulse_sel;
	logic wake_frame_enable;
	logic energy_wake_enable;
	logic [1:0] wake_source_field;
	logic event_status;
	logic pme_event_q;
	logic gpd;
	logic edpd;
	logic energy_flag;
	logic energy_int_en;
	logic energy_q;
	logic energy_sync;
	logic pulse_busy;
	logic resume_done;

	// Address phase decode
	wire accept = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
	wire addr_ok = (haddr[31:8] == ADDR_HIGH_ZERO) && (hsize == HSIZE_WORD);

	// Data phase decode
	wire do_wr = pend && wr_q && valid_q;
	wire do_rd = pend && !wr_q;
	wire sel_pmt = (addr_q == ADDR_PMT);
	wire sel_ists = (addr_q == ADDR_INTERRUPT_STATUS_REG);
	wire sel_bt = (addr_q == ADDR_BYTE_TEST);
	wire sel_phy = (addr_q == ADDR_PHY_CTRL);
	wire sleeping = (state != normal_state);

	// Write qualification
	wire wake_wr = do_wr && sel_bt && sleeping;
	wire cfg_wr = do_wr && read_seen && ready && !sleeping;
	wire pmt_wr = cfg_wr && sel_pmt;
	wire ists_wr = cfg_wr && sel_ists;
	wire phy_wr = cfg_wr && sel_phy;
	wire [1:0] new_mode = hwdata[PMT_MODE_HI:PMT_MODE_LO];
	wire enter_won = pmt_wr && (new_mode == MODE_WON);
	wire enter_ed = pmt_wr && (new_mode == MODE_ENERGY);

	// Next power state
	wire power_state_t next_state = wake_wr ? normal_state :
		enter_won ? wake_on_network_state :
		enter_ed ? energy_detect_state : state;

	// Wake detection and internal event
	wire frame_hit = (state == wake_on_network_state) && wake_frame_detect;
	wire energy_hit = (state == energy_detect_state) && energy_sync && energy_wake_enable;
	wire [1:0] ws_set = {frame_hit, energy_hit};
	wire [1:0] ws_clr = pmt_wr ? hwdata[PMT_WS_HI:PMT_WS_LO] : WS_NONE;
	wire [1:0] next_ws = (wake_source_field & ~ws_clr) | ws_set;
	wire pme_event = (wake_source_field[1] && wake_frame_enable) ||
		(wake_source_field[0] && energy_wake_enable);
	wire event_clr = ists_wr && hwdata[INT_EVENT_BIT];
	wire next_event_status = pme_event || (event_status && !event_clr);
	wire pulse_start = pme_event && !pme_event_q;
	wire next_pme_pin = pme_en && pme_event && (pulse_sel ? pulse_busy : 1'b1);

	// PHY side
	wire next_gpd = phy_wr ? hwdata[PHY_GPD_BIT] : gpd;
	wire energy_rise = energy_sync && !energy_q && edpd;
	wire flag_clr = phy_wr && hwdata[PHY_ED_FLAG_BIT];

	// Read data
	wire [1:0] mode_code = (state == wake_on_network_state) ? MODE_WON :
		(state == energy_detect_state) ? MODE_ENERGY : MODE_NORMAL;
	wire [31:0] rd_pmt = {17'h0, energy_wake_enable, mode_code, 2'h0, wake_frame_enable,
		3'h0, wake_source_field, pulse_sel, 1'b0, pme_en, ready};
	wire [31:0] rd_ists = {31'h0, event_status};
	wire [31:0] rd_phy = {18'h0, edpd, 1'b0, gpd, 6'h0, energy_sync, 2'h0,
		energy_flag, energy_int_en};
	wire [31:0] rd_mux = !valid_q ? 32'h0 :
		sel_pmt ? rd_pmt :
		!ready ? 32'h0 :
		sel_ists ? rd_ists :
		sel_bt ? BYTE_TEST_PATTERN :
		sel_phy ? rd_phy : 32'h0;

	input_sync3 energy_sync_i (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in(carrier_energy_in),
		.sync_out(energy_sync)
	);

	countdown_timer #(.CYCLES(PULSE_CYCLES), .W(TIMER_W)) pulse_timer_i (
		.mclk(mclk),
		.rst_n(rst_n),
		.start(pulse_start),
		.busy(pulse_busy),
		.done()
	);

	countdown_timer #(.CYCLES(RESUME_CYCLES), .W(TIMER_W)) resume_timer_i (
		.mclk(mclk),
		.rst_n(rst_n),
		.start(wake_wr),
		.busy(),
		.done(resume_done)
	);

	// AHB-Lite slave: one wait state per transfer
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend <= 1'b0;
			wr_q <= 1'b0;
			valid_q <= 1'b0;
			addr_q <= 8'h00;
			hreadyout <= 1'b1;
			hrdata <= 32'h0;
			hresp <= HRESP_OKAY;
		end
		else if (pend)
		begin
			pend <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= wr_q ? 32'h0 : rd_mux;
		end
		else if (accept)
		begin
			pend <= 1'b1;
			wr_q <= hwrite;
			valid_q <= addr_ok;
			addr_q <= haddr[7:0];
			hreadyout <= 1'b0;
		end
	end

	// Power state and ready flag
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= normal_state;
			ready <= 1'b1;
			read_seen <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (enter_won || enter_ed)
				ready <= 1'b0;
			else if (resume_done)
				ready <= 1'b1;
			if (wake_wr)
				read_seen <= 1'b0;
			else if (do_rd)
				read_seen <= 1'b1;
		end
	end

	// Clock gating follows the state entered
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			host_mac_clk_en <= 1'b1;
			rx_pm_clk_en <= 1'b1;
			internal_clk_en <= 1'b1;
		end
		else
		begin
			host_mac_clk_en <= (next_state == normal_state);
			rx_pm_clk_en <= (next_state != energy_detect_state);
			internal_clk_en <= (next_state != energy_detect_state);
		end
	end

	// Configuration changes only by accepted writes
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pme_en <= 1'b0;
			pulse_sel <= 1'b0;
			wake_frame_enable <= 1'b0;
			energy_wake_enable <= 1'b0;
		end
		else if (pmt_wr)
		begin
			pme_en <= hwdata[PMT_PME_EN_BIT];
			pulse_sel <= hwdata[PMT_PULSE_BIT];
			wake_frame_enable <= hwdata[PMT_WFE_BIT];
			energy_wake_enable <= hwdata[PMT_EDE_BIT];
		end
	end

	// Wake source, event status and event pin
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wake_source_field <= WS_NONE;
			event_status <= 1'b0;
			pme_event_q <= 1'b0;
			pme_pin <= 1'b0;
		end
		else
		begin
			wake_source_field <= next_ws;
			event_status <= next_event_status;
			pme_event_q <= pme_event;
			pme_pin <= next_pme_pin;
		end
	end

	// Internal PHY power-down control
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gpd <= 1'b0;
			edpd <= 1'b0;
			energy_int_en <= 1'b0;
			energy_flag <= 1'b0;
			energy_q <= 1'b0;
			phy_reset <= 1'b0;
			phy_general_powerdown <= 1'b0;
			phy_energy_powerdown <= 1'b0;
			line_energy_present <= 1'b0;
			phy_irq <= 1'b0;
		end
		else
		begin
			gpd <= next_gpd;
			if (phy_wr)
			begin
				edpd <= hwdata[PHY_EDPD_BIT];
				energy_int_en <= hwdata[PHY_ED_INT_EN_BIT];
			end
			energy_flag <= energy_rise || (energy_flag && !flag_clr);
			energy_q <= energy_sync;
			phy_reset <= gpd && !next_gpd;
			phy_general_powerdown <= gpd;
			phy_energy_powerdown <= edpd && !energy_sync;
			line_energy_present <= energy_sync;
			phy_irq <= energy_flag && energy_int_en;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_sleep_clears_ready: assert property ((enter_won || enter_ed) |=> !ready)
		else $error("ready not cleared on sleep entry");
	a_config_retained: assert property (!pmt_wr |=> $stable(pme_en) && $stable(pulse_sel))
		else $error("configuration changed without write");
	a_write_needs_read: assert property ((do_wr && sel_pmt && !read_seen) |=> $stable(pme_en))
		else $error("write acted before first read");
	a_wake_to_normal: assert property (wake_wr |=> state == normal_state && mode_code == MODE_NORMAL)
		else $error("wake write did not return to normal");
	a_won_clocks: assert property (enter_won |=> !host_mac_clk_en && rx_pm_clk_en)
		else $error("clock gating wrong in wake-on-network sleep");
	a_frame_source: assert property (frame_hit |=> wake_source_field[1])
		else $error("frame detection did not set wake source");
	a_pin_enabled: assert property (pme_pin |-> $past(pme_en) && $past(pme_event))
		else $error("event pin active without enables");
	a_ed_clocks: assert property (enter_ed |=> !internal_clk_en && !host_mac_clk_en && !ready)
		else $error("energy sleep did not stop clocks");
	a_energy_source: assert property (energy_hit |=> wake_source_field[0])
		else $error("energy detection did not set wake source");
	a_status_holds: assert property (pme_event |=> event_status)
		else $error("status bit not held by event");
	a_pulse_static: assert property ((!pulse_sel && pme_en && pme_event) [*2] |=> pme_pin)
		else $error("static event pin not held");
	a_phy_reset: assert property ($fell(gpd) |-> phy_reset)
		else $error("PHY reset missing on power-up");
	a_edpd_off: assert property (phy_energy_powerdown |-> $past(edpd) && !$past(energy_sync))
		else $error("energy power-down without bit");
	a_resume_ready: assert property (wake_wr |=> !ready [*2])
		else $error("ready set before resume finished");

endmodule

// [dv/line_side_model.sv]
`timescale 1ns/1ps
module line_side_model
(
	input wire logic mclk,
	input wire logic frame_req,
	input wire logic energy_req,
	output logic wake_frame_detect,
	output logic carrier_energy_in
);
	// Quiet line and no frame until asked
	initial
	begin
		wake_frame_detect = 1'b0;
		carrier_energy_in = 1'b0;
	end
	// Frame detection is a strobe from the receive logic, same clock
	always @(posedge mclk)
	begin
		wake_frame_detect <= frame_req;
	end
	// Line energy is unrelated to the clock, so it moves off the edge
	always @(energy_req)
	begin
		carrier_energy_in <= #37 energy_req;
	end
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top
	import power_state_pkg::*;
;
	localparam int PULSE = 20;
	localparam logic [31:0] EDPD_B = 32'h1 << PHY_EDPD_BIT;
	localparam logic [31:0] IEN_B = 32'h1 << PHY_ED_INT_EN_BIT;
	localparam logic [31:0] FLAG_B = 32'h1 << PHY_ED_FLAG_BIT;
	localparam logic [31:0] GPD_B = 32'h1 << PHY_GPD_BIT;
	localparam logic [31:0] LINE_B = 32'h10;
	logic mclk, rst_n, hsel, hwrite, frame_req, energy_req;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, hresp;
	logic [2:0] hsize;
	logic hreadyout, wake_frame_detect, carrier_energy_in, pme_pin, host_mac_clk_en;
	logic rx_pm_clk_en, internal_clk_en, phy_general_powerdown, phy_energy_powerdown;
	logic phy_reset, line_energy_present, phy_irq, wfe, pme;
	int bad_count, num_checks, resets, n;

	ethernet_power_state_manager #(.PULSE_CYCLES(PULSE), .RESUME_CYCLES(5))
		ethernet_power_state_manager_i (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.wake_frame_detect(wake_frame_detect), .carrier_energy_in(carrier_energy_in),
		.pme_pin(pme_pin), .host_mac_clk_en(host_mac_clk_en), .rx_pm_clk_en(rx_pm_clk_en),
		.internal_clk_en(internal_clk_en), .phy_general_powerdown(phy_general_powerdown),
		.phy_energy_powerdown(phy_energy_powerdown), .phy_reset(phy_reset),
		.line_energy_present(line_energy_present), .phy_irq(phy_irq));

	line_side_model line_side_model_i (.mclk(mclk), .frame_req(frame_req),
		.energy_req(energy_req), .wake_frame_detect(wake_frame_detect),
		.carrier_energy_in(carrier_energy_in));

	// Clock and a running count of PHY reset strobes
	always #50 mclk = ~mclk;
	always @(negedge mclk)
	begin
		if (phy_reset === 1'b1)
			resets++;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("unexpected %s: expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask

	task automatic cycles(input int k);
		repeat (k) @(negedge mclk);
	endtask

	// Bounded wait for the slave, looked at mid-cycle
	task automatic wait_bus();
		int k;
		for (k = 0; k < 20 && hreadyout !== 1'b1; k++)
			@(negedge mclk);
		check("bus ready", 1, hreadyout);
		if (hreadyout !== 1'b1)
			complete_run();
	endtask

	// One single word transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rv);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {ADDR_HIGH_ZERO, a};
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		@(negedge mclk);
		wait_bus();
		@(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(negedge mclk);
		wait_bus();
		rv = hrdata;
		check("response", HRESP_OKAY, hresp);
		@(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		bus(1'b1, a, d, v);
	endtask

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		check(what, exp, v);
	endtask

	// Poll the control register until ready comes back
	task automatic poll();
		logic [31:0] v;
		int k;
		v = 32'h0;
		for (k = 0; k < 40 && v[PMT_READY_BIT] !== 1'b1; k++)
			bus(1'b0, ADDR_PMT, 32'h0, v);
		check("ready", 1, v[PMT_READY_BIT]);
		if (v[PMT_READY_BIT] !== 1'b1)
			complete_run();
	endtask

	// Length of the next event pin pulse in cycles
	task automatic pulse_len(output int len);
		int k;
		len = 0;
		for (k = 0; k < 20 && pme_pin !== 1'b1; k++)
			@(negedge mclk);
		while (pme_pin === 1'b1 && len < 100)
		begin
			@(negedge mclk);
			len++;
		end
	endtask

	// Expected control register word
	function automatic logic [31:0] pmt(input logic rdy, input logic pe, input logic pls,
		input logic [1:0] ws, input logic we, input logic [1:0] md, input logic ee);
		logic [31:0] w;
		w = {31'h0, rdy} << PMT_READY_BIT;
		w |= ({31'h0, pe} << PMT_PME_EN_BIT) | ({31'h0, pls} << PMT_PULSE_BIT);
		w |= ({30'h0, ws} << PMT_WS_LO) | ({31'h0, we} << PMT_WFE_BIT);
		w |= ({30'h0, md} << PMT_MODE_LO) | ({31'h0, ee} << PMT_EDE_BIT);
		return w;
	endfunction

	initial
	begin
		mclk = 1'b0;
		rst_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		frame_req = 1'b0;
		energy_req = 1'b0;
		bad_count = 0;
		num_checks = 0;
		resets = 0;
		void'($urandom(5));
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		// Writes before the first read are dropped
		wr(ADDR_PMT, pmt(0, 1, 0, 0, 1, 0, 1));
		rdc("pmt after reset", ADDR_PMT, pmt(1, 0, 0, 0, 0, 0, 0));
		rdc("byte test", ADDR_BYTE_TEST, BYTE_TEST_PATTERN);
		rdc("unmapped", 8'h10, 32'h0);
		$display("test reset done");
		// Wake-on-network sleep for every mix of frame enable and pin enable
		for (int i = 0; i < 4; i++)
		begin
			wfe = i[0];
			pme = i[1];
			wr(ADDR_PMT, pmt(0, pme, 0, 0, wfe, MODE_NORMAL, 0));
			wr(ADDR_PMT, pmt(0, pme, 0, 0, wfe, MODE_WON, 0));
			@(negedge mclk);
			check("host clock off", 0, host_mac_clk_en);
			check("rx clock on", 1, rx_pm_clk_en);
			check("internal clock on", 1, internal_clk_en);
			rdc("pmt asleep", ADDR_PMT, pmt(0, pme, 0, 0, wfe, MODE_WON, 0));
			rdc("blocked read", ADDR_BYTE_TEST, 32'h0);
			@(posedge mclk);
			frame_req <= 1'b1;
			@(posedge mclk);
			frame_req <= 1'b0;
			cycles(4);
			check("pin static", {31'h0, pme & wfe}, pme_pin);
			rdc("source frame", ADDR_PMT, pmt(0, pme, 0, WS_FRAME, wfe, MODE_WON, 0));
			cycles(PULSE + 10);
			check("pin held", {31'h0, pme & wfe}, pme_pin);
			wr(ADDR_BYTE_TEST, $urandom);
			@(negedge mclk);
			check("host clock on", 1, host_mac_clk_en);
			poll();
			rdc("pmt awake", ADDR_PMT, pmt(1, pme, 0, WS_FRAME, wfe, 0, 0));
			wr(ADDR_INTERRUPT_STATUS_REG, 32'h1);
			rdc("status held", ADDR_INTERRUPT_STATUS_REG, {31'h0, wfe});
			wr(ADDR_PMT, pmt(0, pme, 0, 2'h3, wfe, MODE_NORMAL, 0));
			cycles(3);
			check("pin cleared", 0, pme_pin);
			wr(ADDR_INTERRUPT_STATUS_REG, 32'h1);
			rdc("status cleared", ADDR_INTERRUPT_STATUS_REG, 32'h0);
		end
		$display("test wake on network done");
		// Energy power-down, quiet line then energy arriving
		wr(ADDR_PHY_CTRL, EDPD_B | IEN_B);
		cycles(6);
		check("phy asleep", 1, phy_energy_powerdown);
		@(posedge mclk);
		energy_req <= 1'b1;
		cycles(8);
		check("phy awake", 0, phy_energy_powerdown);
		check("energy seen", 1, line_energy_present);
		check("phy irq", 1, phy_irq);
		rdc("phy flags", ADDR_PHY_CTRL, EDPD_B | IEN_B | FLAG_B | LINE_B);
		wr(ADDR_PHY_CTRL, EDPD_B | FLAG_B);
		cycles(2);
		check("phy irq off", 0, phy_irq);
		$display("test energy detect done");
		// Energy sleep entered with carrier already present, pulsed pin
		wr(ADDR_PMT, pmt(0, 1, 1, 0, 0, MODE_NORMAL, 1));
		wr(ADDR_PMT, pmt(0, 1, 1, 0, 0, MODE_ENERGY, 1));
		@(negedge mclk);
		check("internal clock off", 0, internal_clk_en);
		check("host clock off", 0, host_mac_clk_en);
		check("rx clock off", 0, rx_pm_clk_en);
		pulse_len(n);
		check("pulse length", PULSE, n);
		rdc("source energy", ADDR_PMT, pmt(0, 1, 1, WS_ENERGY, 0, MODE_ENERGY, 1));
		wr(ADDR_BYTE_TEST, $urandom);
		poll();
		wr(ADDR_PHY_CTRL, 32'h0);
		wr(ADDR_PMT, pmt(0, 1, 1, 2'h3, 0, MODE_NORMAL, 1));
		rdc("pmt clean", ADDR_PMT, pmt(1, 1, 1, 0, 0, MODE_NORMAL, 1));
		$display("test energy sleep done");
		// General power-down and the reset on leaving it
		wr(ADDR_PHY_CTRL, GPD_B);
		cycles(2);
		check("general down", 1, phy_general_powerdown);
		n = resets;
		wr(ADDR_PHY_CTRL, 32'h0);
		cycles(3);
		check("general up", 0, phy_general_powerdown);
		check("phy reset pulses", 1, resets - n);
		$display("test general power-down done");
		complete_run();
	end
endmodule
